// ===== include/sae_map.svh
// register offsets, field positions and timing counts
// assumes: included by the package and the axis module, bare name
`ifndef SAE_MAP_SVH
`define SAE_MAP_SVH

`define SAE_ADDR_W        8
`define SAE_OFF_COIL_OPT  8'hcc
`define SAE_OFF_LOAD      8'hce
`define SAE_OFF_EXT_ERR   8'hcf
`define SAE_OFF_FAULT     8'hd0
`define SAE_OFF_ENC_CNT   8'hd1
`define SAE_OFF_ZERO_ARM  8'hd2
`define SAE_OFF_CFG       8'he0
`define SAE_OFF_IRQ_STAT  8'he1
`define SAE_OFF_IRQ_MASK  8'he2

`define SAE_EXT_STALL     0
`define SAE_EXT_DEV       1

`define SAE_FLT_STALL     0
`define SAE_FLT_OVT       1
`define SAE_FLT_OVT_WARN  2
`define SAE_FLT_SHORT_A   3
`define SAE_FLT_SHORT_B   4
`define SAE_FLT_OPEN_A    5
`define SAE_FLT_OPEN_B    6
`define SAE_FLT_STILL     7

`define SAE_CFG_STBY_ZERO 0
`define SAE_CFG_QUIET     1

`define SAE_IRQ_STALL     0
`define SAE_IRQ_DEV       1
`define SAE_IRQ_OVT       2
`define SAE_IRQ_SHORT     3
`define SAE_IRQ_ZERO_CLR  4
`define SAE_IRQ_W         5

`define SAE_STILL_LOG2    20
`define SAE_STILL_CYCLES  (1 << `SAE_STILL_LOG2)
`define SAE_STILL_W       21

`endif

// ===== include/sae_pkg.sv
// types shared by the axis status and encoder block
// assumes: sae_map.svh on the include path
package sae_pkg;
  `include "sae_map.svh"

  typedef enum logic [1:0] {
    SAE_COIL_NORMAL,
    SAE_COIL_FREEWHEEL,
    SAE_COIL_SHORT_LS,
    SAE_COIL_SHORT_HS
  } sae_coil_t;

  // raw driver stage pins, asynchronous to clk_sys
  typedef struct packed {
    logic stall;
    logic ovt;
    logic ovt_warn;
    logic short_a;
    logic short_b;
    logic chop_a;
    logic chop_b;
    logic pol_a;
    logic pol_b;
    logic step;
  } sae_drv_t;

  // built-in encoder decoder outputs, on clk_sys
  typedef struct packed {
    logic inc;
    logic dec;
    logic at_zero;
  } sae_enc_t;

  typedef struct packed {
    sae_drv_t                   drv_s1;
    sae_drv_t                   drv_s2;
    sae_drv_t                   drv_prev;
    sae_coil_t                  coil_opt;
    sae_coil_t                  coil_out;
    logic                       stby_zero;
    logic                       quiet;
    logic [1:0]                 ext_err;
    logic [1:0]                 chop_seen;
    logic [1:0]                 open_load;
    logic [`SAE_STILL_W-1:0]    still_cnt;
    logic                       standstill;
    logic [31:0]                enc_cnt;
    logic                       zero_arm;
    logic [`SAE_IRQ_W-1:0]      irq_stat;
    logic [`SAE_IRQ_W-1:0]      irq_mask;
    logic [31:0]                rdata;
  } sae_state_t;
endpackage

// ===== src/sae_axis.sv
// axis status and built-in encoder logic for one stepper axis
// assumes: driver pins async (synchronised here); encoder, load and
// deviation inputs come from logic on clk_sys
// Function
// - standstill coil option applies only with zero standby current and quiet chopper
// - option code: 0 normal, 1 freewheel, 2 low-side short, 3 high-side short
// - read-only load measurement 0..1023 from stall detection
// - extended errors: weight 1 stall, weight 2 position deviation
// - extended errors clear after being read or on a motion command
// - fault bits 0 stall, 1 overtemperature shutdown, 2 temperature pre-warning
// - fault bits 3/4 short to ground A/B; driver shut down while set
// - open-load bits 5/6 when no chopper event during last constant polarity
// - fault bit 7 standstill when no step pulse in last 2^20 cycles
// - encoder count signed 32-bit, readable and writable
// - armed clear-on-zero clears encoder count at zero position
// - clear-on-zero arm returns to 0 after performing the clear
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "sae_map.svh"

module sae_axis
  import sae_pkg::*;
#(
  parameter int STILL_CYCLES = `SAE_STILL_CYCLES
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic [`SAE_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  output logic      [31:0]            rdata,
  input  wire sae_drv_t               drv_pins,
  input  wire sae_enc_t               enc,
  input  wire logic [9:0]             load_value,
  input  wire logic                   deviation_err,
  input  wire logic                   motion_cmd,
  output sae_coil_t                   coil_mode,
  output logic                        driver_shutdown,
  output logic                        irq
);

  sae_state_t st_reg;
  sae_state_t st_next;

  localparam logic [`SAE_STILL_W-1:0] STILL_LIMIT = `SAE_STILL_W'(STILL_CYCLES);

  function automatic logic hit(input logic [`SAE_ADDR_W-1:0] a,
                               input logic [`SAE_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic [7:0]            fault;
  logic                  stall_rise;
  logic                  ovt_rise;
  logic                  short_rise;
  logic                  step_rise;
  logic                  zero_clear;
  logic [1:0]            chop_rise;
  logic [1:0]            pol_change;
  logic [`SAE_IRQ_W-1:0] irq_evt;
  logic [1:0]            ext_set;

  always_comb begin
    fault = '0;
    fault[`SAE_FLT_STALL]    = st_reg.drv_s2.stall;
    fault[`SAE_FLT_OVT]      = st_reg.drv_s2.ovt;
    fault[`SAE_FLT_OVT_WARN] = st_reg.drv_s2.ovt_warn;
    fault[`SAE_FLT_SHORT_A]  = st_reg.drv_s2.short_a;
    fault[`SAE_FLT_SHORT_B]  = st_reg.drv_s2.short_b;
    fault[`SAE_FLT_OPEN_A]   = st_reg.open_load[0];
    fault[`SAE_FLT_OPEN_B]   = st_reg.open_load[1];
    fault[`SAE_FLT_STILL]    = st_reg.standstill;
  end

  // edges use stage two and its delayed copy, never the first stage
  assign stall_rise    = st_reg.drv_s2.stall & ~st_reg.drv_prev.stall;
  assign ovt_rise      = st_reg.drv_s2.ovt & ~st_reg.drv_prev.ovt;
  assign short_rise    = (st_reg.drv_s2.short_a & ~st_reg.drv_prev.short_a)
                       | (st_reg.drv_s2.short_b & ~st_reg.drv_prev.short_b);
  assign step_rise     = st_reg.drv_s2.step & ~st_reg.drv_prev.step;
  assign chop_rise[0]  = st_reg.drv_s2.chop_a & ~st_reg.drv_prev.chop_a;
  assign chop_rise[1]  = st_reg.drv_s2.chop_b & ~st_reg.drv_prev.chop_b;
  assign pol_change[0] = st_reg.drv_s2.pol_a ^ st_reg.drv_prev.pol_a;
  assign pol_change[1] = st_reg.drv_s2.pol_b ^ st_reg.drv_prev.pol_b;
  assign zero_clear    = st_reg.zero_arm & enc.at_zero;

  assign ext_set[`SAE_EXT_STALL] = stall_rise;
  assign ext_set[`SAE_EXT_DEV]   = deviation_err;

  always_comb begin
    irq_evt = '0;
    irq_evt[`SAE_IRQ_STALL]    = stall_rise;
    irq_evt[`SAE_IRQ_DEV]      = deviation_err;
    irq_evt[`SAE_IRQ_OVT]      = ovt_rise;
    irq_evt[`SAE_IRQ_SHORT]    = short_rise;
    irq_evt[`SAE_IRQ_ZERO_CLR] = zero_clear;
  end

  always_comb begin
    st_next = st_reg;
    st_next.drv_s1   = drv_pins;
    st_next.drv_s2   = st_reg.drv_s1;
    st_next.drv_prev = st_reg.drv_s2;

    // open load: judged at each polarity reversal, per coil
    for (int c = 0; c < 2; c++) begin
      if (pol_change[c]) begin
        st_next.open_load[c] = ~(st_reg.chop_seen[c] | chop_rise[c]);
        st_next.chop_seen[c] = 1'b0;
      end else if (chop_rise[c]) begin
        st_next.chop_seen[c] = 1'b1;
      end
    end

    // standstill counter saturates so it cannot wrap back to moving
    if (step_rise) begin
      st_next.still_cnt  = '0;
      st_next.standstill = 1'b0;
    end else if (st_reg.still_cnt >= STILL_LIMIT - `SAE_STILL_W'(1)) begin
      st_next.still_cnt  = STILL_LIMIT;
      st_next.standstill = 1'b1;
    end else begin
      st_next.still_cnt = st_reg.still_cnt + `SAE_STILL_W'(1);
    end

    // extended errors: a new event wins over a same-cycle clear
    if ((rd_en && hit(addr, `SAE_OFF_EXT_ERR)) || motion_cmd) begin
      st_next.ext_err = ext_set;
    end else begin
      st_next.ext_err = st_reg.ext_err | ext_set;
    end

    // encoder count: host write beats zero clear beats counting
    if (wr_en && hit(addr, `SAE_OFF_ENC_CNT)) begin
      st_next.enc_cnt = wdata;
    end else if (zero_clear) begin
      st_next.enc_cnt = '0;
    end else if (enc.inc && !enc.dec) begin
      st_next.enc_cnt = st_reg.enc_cnt + 32'h0000_0001;
    end else if (enc.dec && !enc.inc) begin
      st_next.enc_cnt = st_reg.enc_cnt - 32'h0000_0001;
    end

    if (wr_en && hit(addr, `SAE_OFF_ZERO_ARM)) begin
      st_next.zero_arm = wdata[0];
    end else if (zero_clear) begin
      st_next.zero_arm = 1'b0;
    end

    if (wr_en && hit(addr, `SAE_OFF_COIL_OPT)) begin
      st_next.coil_opt = sae_coil_t'(wdata[1:0]);
    end
    if (wr_en && hit(addr, `SAE_OFF_CFG)) begin
      st_next.stby_zero = wdata[`SAE_CFG_STBY_ZERO];
      st_next.quiet     = wdata[`SAE_CFG_QUIET];
    end
    if (wr_en && hit(addr, `SAE_OFF_IRQ_MASK)) begin
      st_next.irq_mask = wdata[`SAE_IRQ_W-1:0];
    end
    if (wr_en && hit(addr, `SAE_OFF_IRQ_STAT)) begin
      st_next.irq_stat = (st_reg.irq_stat & ~wdata[`SAE_IRQ_W-1:0]) | irq_evt;
    end else begin
      st_next.irq_stat = st_reg.irq_stat | irq_evt;
    end

    // option only reaches the bridge under both conditions
    if (st_reg.stby_zero && st_reg.quiet) begin
      st_next.coil_out = st_reg.coil_opt;
    end else begin
      st_next.coil_out = SAE_COIL_NORMAL;
    end

    st_next.rdata = '0;
    if (rd_en) begin
      unique case (addr)
        `SAE_OFF_COIL_OPT: st_next.rdata[1:0] = st_reg.coil_opt;
        `SAE_OFF_LOAD:     st_next.rdata[9:0] = load_value;
        `SAE_OFF_EXT_ERR:  st_next.rdata[1:0] = st_reg.ext_err;
        `SAE_OFF_FAULT:    st_next.rdata[7:0] = fault;
        `SAE_OFF_ENC_CNT:  st_next.rdata = st_reg.enc_cnt;
        `SAE_OFF_ZERO_ARM: st_next.rdata[0] = st_reg.zero_arm;
        `SAE_OFF_CFG: begin
          st_next.rdata[`SAE_CFG_STBY_ZERO] = st_reg.stby_zero;
          st_next.rdata[`SAE_CFG_QUIET]     = st_reg.quiet;
        end
        `SAE_OFF_IRQ_STAT: st_next.rdata[`SAE_IRQ_W-1:0] = st_reg.irq_stat;
        `SAE_OFF_IRQ_MASK: st_next.rdata[`SAE_IRQ_W-1:0] = st_reg.irq_mask;
        default:           st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata           = st_reg.rdata;
  assign coil_mode       = st_reg.coil_out;
  // overtemperature or either short holds the bridge off
  assign driver_shutdown = st_reg.drv_s2.ovt | st_reg.drv_s2.short_a
                         | st_reg.drv_s2.short_b;
  assign irq             = |(st_reg.irq_stat & st_reg.irq_mask);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_rd_ext;
    rd_en && addr == `SAE_OFF_EXT_ERR;
  endsequence

  sequence s_zero_hit;
    st_reg.zero_arm && enc.at_zero && !(wr_en && addr == `SAE_OFF_ENC_CNT);
  endsequence

  property p_coil_gate;
    !($past(st_reg.stby_zero) && $past(st_reg.quiet)) |-> coil_mode == SAE_COIL_NORMAL;
  endproperty
  a_coil_gate: assert property (p_coil_gate) else $error("coil option applied while gated");

  property p_coil_pass;
    st_reg.stby_zero && st_reg.quiet |=> coil_mode == $past(st_reg.coil_opt);
  endproperty
  a_coil_pass: assert property (p_coil_pass) else $error("coil option not applied");

  property p_load_read;
    rd_en && addr == `SAE_OFF_LOAD |=> rdata == {22'h0, $past(load_value)};
  endproperty
  a_load_read: assert property (p_load_read) else $error("load readout wrong");

  property p_ext_dev_set;
    deviation_err |=> st_reg.ext_err[`SAE_EXT_DEV];
  endproperty
  a_ext_dev_set: assert property (p_ext_dev_set) else $error("deviation flag not set");

  property p_ext_clear;
    s_rd_ext ##0 !stall_rise ##0 !deviation_err |=> st_reg.ext_err == 2'h0;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("ext errors kept after read");

  property p_ext_readback;
    s_rd_ext |=> rdata == {30'h0, $past(st_reg.ext_err)};
  endproperty
  a_ext_readback: assert property (p_ext_readback) else $error("ext error readback wrong");

  property p_fault_stall;
    $rose(drv_pins.stall) ##1 drv_pins.stall [*2] |=> fault[`SAE_FLT_STALL];
  endproperty
  a_fault_stall: assert property (p_fault_stall) else $error("stall bit late");

  property p_shutdown;
    fault[`SAE_FLT_SHORT_A] || fault[`SAE_FLT_SHORT_B] |-> driver_shutdown;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("driver on during short");

  property p_open_load;
    pol_change[0] && !st_reg.chop_seen[0] && !chop_rise[0] |=> fault[`SAE_FLT_OPEN_A];
  endproperty
  a_open_load: assert property (p_open_load) else $error("open load A missed");

  property p_still_clear;
    step_rise |=> !st_reg.standstill ##1 !fault[`SAE_FLT_STILL];
  endproperty
  a_still_clear: assert property (p_still_clear) else $error("standstill after step");

  property p_still_need;
    st_reg.standstill |-> st_reg.still_cnt == STILL_LIMIT;
  endproperty
  a_still_need: assert property (p_still_need) else $error("standstill too early");

  property p_zero_clear;
    s_zero_hit ##0 !(wr_en && addr == `SAE_OFF_ZERO_ARM && wdata[0])
      |=> st_reg.enc_cnt == 32'h0 && !st_reg.zero_arm;
  endproperty
  a_zero_clear: assert property (p_zero_clear) else $error("zero clear failed");

  property p_zero_once;
    s_zero_hit ##1 !(wr_en && addr == `SAE_OFF_ZERO_ARM) |=> !st_reg.zero_arm;
  endproperty
  a_zero_once: assert property (p_zero_once) else $error("arm not released");

  property p_enc_write;
    wr_en && addr == `SAE_OFF_ENC_CNT |=> st_reg.enc_cnt == $past(wdata);
  endproperty
  a_enc_write: assert property (p_enc_write) else $error("encoder load failed");

  property p_enc_count;
    enc.inc && !enc.dec && !zero_clear && !(wr_en && addr == `SAE_OFF_ENC_CNT)
      |=> st_reg.enc_cnt == $past(st_reg.enc_cnt) + 32'h1;
  endproperty
  a_enc_count: assert property (p_enc_count) else $error("encoder did not count");

  property p_rdata_idle;
    !rd_en |=> rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not back to zero");

  property p_coil_code;
    wr_en && addr == `SAE_OFF_COIL_OPT |=> st_reg.coil_opt == $past(wdata[1:0]);
  endproperty
  a_coil_code: assert property (p_coil_code) else $error("coil option not stored");

  property p_ext_stall_set;
    stall_rise |=> st_reg.ext_err[`SAE_EXT_STALL];
  endproperty
  a_ext_stall_set: assert property (p_ext_stall_set) else $error("stall flag not set");

  property p_ext_hold;
    st_reg.ext_err[`SAE_EXT_STALL] && !(rd_en && addr == `SAE_OFF_EXT_ERR) && !motion_cmd
      |=> st_reg.ext_err[`SAE_EXT_STALL];
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("stall flag lost unread");

  property p_ext_motion;
    motion_cmd && !stall_rise && !deviation_err |=> st_reg.ext_err == 2'h0;
  endproperty
  a_ext_motion: assert property (p_ext_motion) else $error("motion kept ext errors");

  // a pin held for three samples has crossed both stages
  sequence s_ovt_held;
    $rose(drv_pins.ovt) ##1 drv_pins.ovt [*2];
  endsequence

  property p_fault_ovt;
    s_ovt_held |=> fault[`SAE_FLT_OVT] && driver_shutdown;
  endproperty
  a_fault_ovt: assert property (p_fault_ovt) else $error("overtemp not reported");

  property p_fault_warn;
    $rose(drv_pins.ovt_warn) ##1 drv_pins.ovt_warn [*2] |=> fault[`SAE_FLT_OVT_WARN];
  endproperty
  a_fault_warn: assert property (p_fault_warn) else $error("pre-warning not reported");

  property p_short_a;
    $rose(drv_pins.short_a) ##1 drv_pins.short_a [*2]
      |=> fault[`SAE_FLT_SHORT_A] && driver_shutdown;
  endproperty
  a_short_a: assert property (p_short_a) else $error("short A not reported");

  property p_short_b;
    $rose(drv_pins.short_b) ##1 drv_pins.short_b [*2]
      |=> fault[`SAE_FLT_SHORT_B] && driver_shutdown;
  endproperty
  a_short_b: assert property (p_short_b) else $error("short B not reported");

  property p_open_load_b;
    pol_change[1] && !st_reg.chop_seen[1] && !chop_rise[1] |=> fault[`SAE_FLT_OPEN_B];
  endproperty
  a_open_load_b: assert property (p_open_load_b) else $error("open load B missed");

  property p_open_ok;
    pol_change[0] && (st_reg.chop_seen[0] || chop_rise[0]) |=> !fault[`SAE_FLT_OPEN_A];
  endproperty
  a_open_ok: assert property (p_open_ok) else $error("open load A false");

  property p_open_hold;
    !pol_change[1] |=> $stable(st_reg.open_load[1]);
  endproperty
  a_open_hold: assert property (p_open_hold) else $error("open load B moved");

  property p_still_set;
    !step_rise && st_reg.still_cnt == STILL_LIMIT - `SAE_STILL_W'(1) |=> st_reg.standstill;
  endproperty
  a_still_set: assert property (p_still_set) else $error("standstill not set");

  property p_enc_dec;
    enc.dec && !enc.inc && !zero_clear && !(wr_en && addr == `SAE_OFF_ENC_CNT)
      |=> st_reg.enc_cnt == $past(st_reg.enc_cnt) - 32'h1;
  endproperty
  a_enc_dec: assert property (p_enc_dec) else $error("encoder did not count down");

  property p_enc_read;
    rd_en && addr == `SAE_OFF_ENC_CNT |=> rdata == $past(st_reg.enc_cnt);
  endproperty
  a_enc_read: assert property (p_enc_read) else $error("encoder readback wrong");

  property p_arm_hold;
    !st_reg.zero_arm && !(wr_en && addr == `SAE_OFF_ZERO_ARM) |=> !st_reg.zero_arm;
  endproperty
  a_arm_hold: assert property (p_arm_hold) else $error("arm set without write");

  property p_zero_irq;
    zero_clear |=> st_reg.irq_stat[`SAE_IRQ_ZERO_CLR];
  endproperty
  a_zero_irq: assert property (p_zero_irq) else $error("zero clear event lost");

endmodule

// ===== tb/sae_axis_tb.sv
// self-checking bench for the axis status and encoder block
// assumes: sae_drv_model stands in for the driver stage and encoder
`timescale 1ns/1ps

module sae_axis_tb
  import sae_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rdata;
  sae_drv_t    drv_pins;
  sae_enc_t    enc;
  logic [9:0]  load_value;
  logic        deviation_err;
  logic        motion_cmd;
  sae_coil_t   coil_mode;
  logic        driver_shutdown;
  logic        irq;
  int          mismatches = 0;
  int          n_tests = 0;
  logic [31:0] d;

  always #5 clk_sys = !clk_sys;

  // short standstill window keeps the run brief
  sae_axis #(.STILL_CYCLES(16)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .drv_pins(drv_pins), .enc(enc),
    .load_value(load_value), .deviation_err(deviation_err), .motion_cmd(motion_cmd),
    .coil_mode(coil_mode), .driver_shutdown(driver_shutdown), .irq(irq)
  );
  sae_drv_model u_drv (.clk_sys(clk_sys), .drv_pins(drv_pins), .enc(enc));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic pulse(input logic dev);
    @(posedge clk_sys);
    if (dev) deviation_err <= 1'b1;
    else motion_cmd <= 1'b1;
    @(posedge clk_sys);
    deviation_err <= 1'b0;
    motion_cmd <= 1'b0;
  endtask

  task automatic t_coil();
    for (int c = 0; c < 4; c++) begin
      wr(8'hcc, c);
      wr(8'he0, 32'h3);
      repeat (2) @(posedge clk_sys);
      chk({30'h0, coil_mode}, c);
      rd(8'hcc, d);
      chk(d, c);
      for (int k = 0; k < 3; k++) begin
        wr(8'he0, k);
        repeat (2) @(posedge clk_sys);
        chk({30'h0, coil_mode}, 32'h0);
      end
    end
  endtask

  task automatic t_load();
    load_value <= 10'h3ff;
    wr(8'hce, 32'h0);
    rd(8'hce, d);
    chk(d, 32'h3ff);
    load_value <= 10'h155;
    rd(8'hce, d);
    chk(d, 32'h155);
    rd(8'h00, d);
    chk(d, 32'h0);
  endtask

  task automatic t_faults();
    u_drv.set_fault(5'b10000);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rd(8'hcf, d);
    chk(d, 32'h1);
    rd(8'hcf, d);
    chk(d, 32'h0);
    pulse(1'b1);
    rd(8'hcf, d);
    chk(d, 32'h2);
    pulse(1'b0);
    rd(8'hcf, d);
    chk(d, 32'h0);
    wr(8'he2, 32'h1);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    wr(8'he1, 32'h1);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      u_drv.set_fault(5'b10000 >> i);
      repeat (4) @(posedge clk_sys);
      rd(8'hd0, d);
      chk(d & 32'h7f, 32'h1 << i);
      chk({31'h0, driver_shutdown}, (i == 1 || i > 2));
    end
    u_drv.set_fault(5'b00000);
    // deviation, overtemp rise and short rise stay latched; stall was cleared
    rd(8'he1, d);
    chk(d, 32'he);
  endtask

  task automatic t_open();
    for (int s = 0; s < 2; s++) begin
      u_drv.coil_period(s, 1'b0);
      repeat (4) @(posedge clk_sys);
      rd(8'hd0, d);
      chk((d >> (5 + s)) & 32'h1, 32'h1);
      u_drv.coil_period(s, 1'b1);
      repeat (4) @(posedge clk_sys);
      rd(8'hd0, d);
      chk((d >> (5 + s)) & 32'h1, 32'h0);
    end
  endtask

  task automatic t_still();
    int n;
    u_drv.step_pulse();
    repeat (3) @(posedge clk_sys);
    rd(8'hd0, d);
    chk(d & 32'h80, 32'h0);
    n = 0;
    // bounded poll: window is 16 cycles after the step
    while (d[7] !== 1'b1 && n < 20) begin
      rd(8'hd0, d);
      n++;
    end
    chk(d & 32'h80, 32'h80);
  endtask

  task automatic t_enc();
    wr(8'hd1, 32'h7fffffff);
    u_drv.enc_evt(3'b100);
    rd(8'hd1, d);
    chk(d, 32'h80000000);
    u_drv.enc_evt(3'b010);
    rd(8'hd1, d);
    chk(d, 32'h7fffffff);
    wr(8'hd2, 32'h1);
    u_drv.enc_evt(3'b001);
    rd(8'hd1, d);
    chk(d, 32'h0);
    rd(8'hd2, d);
    chk(d, 32'h0);
    rd(8'he1, d);
    chk(d & 32'h10, 32'h10);
    wr(8'hd1, 32'h9);
    u_drv.enc_evt(3'b001);
    rd(8'hd1, d);
    chk(d, 32'h9);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    addr          <= '0;
    wdata         <= '0;
    wr_en         <= 1'b0;
    rd_en         <= 1'b0;
    load_value    <= '0;
    deviation_err <= 1'b0;
    motion_cmd    <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1 chk({30'h0, coil_mode}, 32'h0);
    t_coil();
    t_load();
    t_faults();
    t_open();
    t_still();
    t_enc();
    test_done();
  end
endmodule

// ===== tb/sae_drv_model.sv
// behavioural driver stage and built-in encoder facing one axis block
// assumes: the bench calls the tasks; pins change just after clk_sys edges
`timescale 1ns/1ps

module sae_drv_model
  import sae_pkg::*;
(
  input  wire logic clk_sys,
  output sae_drv_t  drv_pins,
  output sae_enc_t  enc
);
  initial begin
    drv_pins = '0;
    enc      = '0;
  end

  // f = {stall, ovt, ovt_warn, short_a, short_b}, held as levels
  task automatic set_fault(input logic [4:0] f);
    @(posedge clk_sys);
    {drv_pins.stall, drv_pins.ovt, drv_pins.ovt_warn, drv_pins.short_a, drv_pins.short_b} <= f;
  endtask

  // two cycles high so the sync chain cannot miss it
  task automatic step_pulse();
    @(posedge clk_sys);
    drv_pins.step <= 1'b1;
    repeat (2) @(posedge clk_sys);
    drv_pins.step <= 1'b0;
  endtask

  // one constant-polarity period on coil b_side, with or without a chopper event
  task automatic coil_period(input logic b_side, input logic chop);
    if (chop) begin
      @(posedge clk_sys);
      if (b_side) drv_pins.chop_b <= 1'b1;
      else drv_pins.chop_a <= 1'b1;
      repeat (2) @(posedge clk_sys);
      drv_pins.chop_a <= 1'b0;
      drv_pins.chop_b <= 1'b0;
    end
    repeat (2) @(posedge clk_sys);
    if (b_side) drv_pins.pol_b <= !drv_pins.pol_b;
    else drv_pins.pol_a <= !drv_pins.pol_a;
  endtask

  task automatic enc_evt(input sae_enc_t e);
    @(posedge clk_sys);
    enc <= e;
    @(posedge clk_sys);
    enc <= '0;
  endtask
endmodule
